// file: rtl/mbc_params.svh
// constants for the boost mode controller: offsets, resets, timing
`ifndef MBC_PARAMS_SVH
`define MBC_PARAMS_SVH

// register byte offsets
`define MBC_OFS_CTRL 8'h00
`define MBC_OFS_SDUTY 8'h04
`define MBC_OFS_STATUS 8'h08
`define MBC_OFS_DUTY 8'h0C

// reset values and writable masks
`define MBC_CTRL_RESET 32'h00190001
`define MBC_CTRL_WMASK 32'h00FF0001
`define MBC_SDUTY_RESET 32'h000004E2
`define MBC_SDUTY_WMASK 32'h00000FFF

// field positions
`define MBC_CTRL_RUN_BIT 0
`define MBC_CTRL_STEP_LSB 16
`define MBC_CTRL_STEP_MSB 23

// timing
`define MBC_CLK_PERIOD_NS 4
`define MBC_PWM_PERIOD_NS 10000
`define MBC_PWM_CYCLES (`MBC_PWM_PERIOD_NS / `MBC_CLK_PERIOD_NS)
`define MBC_DEAD_NS 40
`define MBC_DEAD_CYCLES ((`MBC_DEAD_NS + `MBC_CLK_PERIOD_NS - 1) / `MBC_CLK_PERIOD_NS)

// duty values in clock counts of one period, and the longest burst spacing in periods
`define MBC_BURST_DUTY (`MBC_PWM_CYCLES / 10)
`define MBC_DUTY_MIN (`MBC_PWM_CYCLES / 20)
`define MBC_DUTY_MAX ((`MBC_PWM_CYCLES * 9) / 10)
`define MBC_BURST_MAX_N 16

`endif

// file: rtl/mbc_pkg.sv
// types for the boost mode controller
package mbc_pkg;
	typedef enum logic [2:0] {
		MBC_ST_OFF,
		MBC_ST_SOFT,
		MBC_ST_STARTUP,
		MBC_ST_TRACK,
		MBC_ST_BURST,
		MBC_ST_SLEEP,
		MBC_ST_OVERTEMP
	} mbc_state_e;
	typedef logic [11:0] mbc_duty_t;
	typedef logic [4:0] mbc_burst_t;
endpackage

// file: rtl/mbc_top.sv
// boost converter mode sequencer, power-point tracker and gate drive
`timescale 1ns/1ns
`default_nettype none
`include "mbc_params.svh"

module mbc_top
	import mbc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// comparators and pins
	input wire logic shutdown_pin_n,
	input wire logic vout_above_0v8,
	input wire logic vout_above_2v,
	input wire logic source_sense_below_off,
	input wire logic source_sense_above_on,
	input wire logic source_reversed,
	input wire logic overcurrent_protection,
	input wire logic overtemperature_protection,
	input wire logic temp_below_130c,
	input wire logic voltage_feedback_at_target,
	input wire logic source_sense_below_450mv,
	input wire logic output_current_limit,
	input wire logic input_power_rose,
	// gate drives
	output logic main_switch_drive,
	output logic rectifier_drive
);

	localparam int NS = 13;
	localparam int I_SHDN = 0;
	localparam int I_V08 = 1;
	localparam int I_V2 = 2;
	localparam int I_SOFF = 3;
	localparam int I_SON = 4;
	localparam int I_REV = 5;
	localparam int I_OVC = 6;
	localparam int I_OVT = 7;
	localparam int I_T130 = 8;
	localparam int I_TGT = 9;
	localparam int I_S450 = 10;
	localparam int I_ILIM = 11;
	localparam int I_PROSE = 12;
	localparam mbc_duty_t PWM_LAST = 12'(`MBC_PWM_CYCLES - 1);
	localparam mbc_duty_t DUTY_BURST = 12'(`MBC_BURST_DUTY);
	localparam mbc_duty_t DUTY_MIN = 12'(`MBC_DUTY_MIN);
	localparam mbc_duty_t DUTY_MAX = 12'(`MBC_DUTY_MAX);
	localparam logic [3:0] DEAD_LOAD = 4'(`MBC_DEAD_CYCLES);
	localparam mbc_burst_t BURST_MAX = 5'(`MBC_BURST_MAX_N);

	logic [NS-1:0] raw_in;
	logic [NS-1:0] meta_reg;
	logic [NS-1:0] sync_reg;
	mbc_state_e state_reg;
	mbc_state_e state_next;
	mbc_duty_t pwm_reg;
	mbc_duty_t duty_reg;
	mbc_burst_t burst_n_reg;
	mbc_burst_t burst_cnt_reg;
	logic dir_reg;
	logic lockout_reg;
	logic ovt_latch_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] sduty_reg;
	logic main_q;
	logic rect_q;
	logic main_prev_reg;
	logic [3:0] dead_reg;
	logic fast_kill;
	logic period_end;
	logic off_cause;
	logic burst_cause;
	logic main_want;
	logic rect_want;
	logic main_next;
	logic rect_next;
	logic dir_next;
	logic [12:0] duty_up;
	mbc_duty_t step;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic rd_ok;

	// two-stage synchronisers
	assign raw_in = {input_power_rose, output_current_limit, source_sense_below_450mv,
		voltage_feedback_at_target, temp_below_130c, overtemperature_protection,
		overcurrent_protection, source_reversed, source_sense_above_on,
		source_sense_below_off, vout_above_2v, vout_above_0v8, shutdown_pin_n};

	generate
		for (genvar gi = 0; gi < NS; gi++)
		begin : g_sync
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					meta_reg[gi] <= 1'b0;
					sync_reg[gi] <= 1'b0;
				end
				else
				begin
					meta_reg[gi] <= raw_in[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	// undervoltage lockout with hysteresis, set wins
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			lockout_reg <= 1'b1;
		else if (sync_reg[I_SOFF])
			lockout_reg <= 1'b1;
		else if (sync_reg[I_SON])
			lockout_reg <= 1'b0;
	end

	// overtemperature latch, set wins
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			ovt_latch_reg <= 1'b0;
		else if (sync_reg[I_OVT])
			ovt_latch_reg <= 1'b1;
		else if (sync_reg[I_T130])
			ovt_latch_reg <= 1'b0;
	end

	assign off_cause = !sync_reg[I_SHDN] || !ctrl_reg[`MBC_CTRL_RUN_BIT] || lockout_reg
		|| sync_reg[I_REV];
	assign burst_cause = sync_reg[I_TGT] || sync_reg[I_S450] || sync_reg[I_ILIM];
	assign period_end = (pwm_reg == PWM_LAST);

	// fixed period counter
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			pwm_reg <= 12'h000;
		else if (period_end)
			pwm_reg <= 12'h000;
		else
			pwm_reg <= pwm_reg + 12'h001;
	end

	// mode sequencer
	always_comb
	begin
		state_next = state_reg;
		if (off_cause)
			state_next = MBC_ST_OFF;
		else if (ovt_latch_reg)
			state_next = MBC_ST_OVERTEMP;
		else
		begin
			unique case (state_reg)
				MBC_ST_OFF: state_next = MBC_ST_SOFT;
				MBC_ST_SOFT:
					if (sync_reg[I_V08])
						state_next = MBC_ST_STARTUP;
				MBC_ST_STARTUP:
					if (sync_reg[I_V2])
						state_next = MBC_ST_TRACK;
					else if (!sync_reg[I_V08])
						state_next = MBC_ST_SOFT;
				MBC_ST_TRACK:
					if (burst_cause)
						state_next = MBC_ST_BURST;
					else if (!sync_reg[I_V08])
						state_next = MBC_ST_SOFT;
				MBC_ST_BURST:
					if (period_end && burst_cnt_reg == burst_n_reg - 5'h01)
					begin
						if (!burst_cause)
							state_next = MBC_ST_TRACK;
						else if (burst_n_reg == BURST_MAX)
							state_next = MBC_ST_SLEEP;
					end
				MBC_ST_SLEEP:
					if (!burst_cause)
						state_next = MBC_ST_TRACK;
				MBC_ST_OVERTEMP: state_next = MBC_ST_SOFT;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			state_reg <= MBC_ST_OFF;
		else
			state_reg <= state_next;
	end

	// burst pulse spacing
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			burst_n_reg <= 5'h01;
			burst_cnt_reg <= 5'h00;
		end
		else if (state_reg != MBC_ST_BURST)
		begin
			burst_n_reg <= 5'h01;
			burst_cnt_reg <= 5'h00;
		end
		else if (period_end && burst_cnt_reg == burst_n_reg - 5'h01)
		begin
			burst_cnt_reg <= 5'h00;
			if (burst_n_reg != BURST_MAX)
				burst_n_reg <= burst_n_reg + 5'h01;
		end
		else if (period_end)
			burst_cnt_reg <= burst_cnt_reg + 5'h01;
	end

	// perturb and observe duty
	assign step = {4'h0, ctrl_reg[`MBC_CTRL_STEP_MSB:`MBC_CTRL_STEP_LSB]};
	assign dir_next = sync_reg[I_PROSE] ? dir_reg : !dir_reg;
	assign duty_up = {1'b0, duty_reg} + {1'b0, step};

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			duty_reg <= 12'h000;
			dir_reg <= 1'b1;
		end
		else if (state_reg != MBC_ST_BURST && state_next == MBC_ST_BURST)
			duty_reg <= DUTY_BURST;
		else if (state_reg == MBC_ST_STARTUP)
			duty_reg <= sduty_reg[11:0];
		else if (state_reg == MBC_ST_TRACK && period_end)
		begin
			dir_reg <= dir_next;
			if (dir_next)
				duty_reg <= (duty_up > {1'b0, DUTY_MAX}) ? DUTY_MAX : duty_up[11:0];
			else
				duty_reg <= (duty_reg < DUTY_MIN + step) ? DUTY_MIN : duty_reg - step;
		end
	end

	// switch requests
	always_comb
	begin
		main_want = 1'b0;
		rect_want = 1'b0;
		unique case (state_reg)
			MBC_ST_STARTUP: main_want = !sync_reg[I_OVC] && pwm_reg < duty_reg;
			MBC_ST_TRACK:
			begin
				main_want = !sync_reg[I_OVC] && pwm_reg < duty_reg;
				rect_want = !main_want;
			end
			MBC_ST_BURST:
			begin
				main_want = !sync_reg[I_OVC] && burst_cnt_reg == 5'h00 && pwm_reg < duty_reg;
				rect_want = sync_reg[I_OVC] || (burst_cnt_reg == 5'h00 && !main_want);
			end
			MBC_ST_OVERTEMP: rect_want = 1'b1;
			default:
			begin
				main_want = 1'b0;
				rect_want = 1'b0;
			end
		endcase
	end

	assign main_next = main_want && !rect_q && dead_reg == 4'h0;
	assign rect_next = rect_want && !main_want && !main_q && !main_prev_reg && dead_reg == 4'h0;
	assign fast_kill = overcurrent_protection || overtemperature_protection;

	// main switch drive, cleared without clock on overcurrent or overtemperature
	always_ff @(posedge clk_sys or negedge reset_n or posedge fast_kill)
	begin
		if (!reset_n)
			main_q <= 1'b0;
		else if (fast_kill)
			main_q <= 1'b0;
		else
			main_q <= main_next;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rect_q <= 1'b0;
			main_prev_reg <= 1'b0;
			dead_reg <= 4'h0;
		end
		else
		begin
			rect_q <= rect_next;
			main_prev_reg <= main_q;
			if ((main_q && !main_next) || (rect_q && !rect_next) || (main_prev_reg && !main_q))
				dead_reg <= DEAD_LOAD;
			else if (dead_reg != 4'h0)
				dead_reg <= dead_reg - 4'h1;
		end
	end

	assign main_switch_drive = main_q;
	assign rectifier_drive = rect_q;

	// axi4-lite write path
	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			ctrl_reg <= `MBC_CTRL_RESET;
			sduty_reg <= `MBC_SDUTY_RESET;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (aw_hold_reg && w_hold_reg && !s_axi_bvalid)
			begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				unique case ({awaddr_reg[7:2], 2'b00})
					`MBC_OFS_CTRL: ctrl_reg <= (ctrl_reg & ~(wmask & `MBC_CTRL_WMASK))
						| (wdata_reg & wmask & `MBC_CTRL_WMASK);
					`MBC_OFS_SDUTY: sduty_reg <= (sduty_reg & ~(wmask & `MBC_SDUTY_WMASK))
						| (wdata_reg & wmask & `MBC_SDUTY_WMASK);
					`MBC_OFS_STATUS, `MBC_OFS_DUTY: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= 2'h2;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// axi4-lite read path
	always_comb
	begin
		rd_ok = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			`MBC_OFS_CTRL: rd_word = ctrl_reg;
			`MBC_OFS_SDUTY: rd_word = sduty_reg;
			`MBC_OFS_STATUS: rd_word = {19'h00000, burst_n_reg, dir_reg, burst_cause,
				sync_reg[I_REV], ovt_latch_reg, lockout_reg, state_reg};
			`MBC_OFS_DUTY: rd_word = {20'h00000, duty_reg};
			default:
			begin
				rd_word = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// checks
	property p_no_overlap;
		@(posedge clk_sys) disable iff (!reset_n)
		!(main_switch_drive && rectifier_drive);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both switches on");

	property p_dead_gap;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(rectifier_drive) |-> !main_switch_drive [*8];
	endproperty
	a_dead_gap: assert property (p_dead_gap) else $error("no dead time after rectifier");

	property p_soft_idle;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == MBC_ST_SOFT |=> !main_switch_drive && !rectifier_drive;
	endproperty
	a_soft_idle: assert property (p_soft_idle) else $error("switch driven in soft-start");

	property p_soft_exit;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == MBC_ST_SOFT && sync_reg[I_V08] && !off_cause && !ovt_latch_reg
		|=> state_reg == MBC_ST_STARTUP;
	endproperty
	a_soft_exit: assert property (p_soft_exit) else $error("soft-start not left");

	property p_startup_rect;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == MBC_ST_STARTUP && $stable(state_reg) |-> !rectifier_drive;
	endproperty
	a_startup_rect: assert property (p_startup_rect) else $error("rectifier on in startup");

	property p_ovc_kill;
		@(posedge clk_sys) disable iff (!reset_n)
		overcurrent_protection |-> !main_switch_drive;
	endproperty
	a_ovc_kill: assert property (p_ovc_kill) else $error("main on during overcurrent");

	property p_shutdown;
		@(posedge clk_sys) disable iff (!reset_n)
		!sync_reg[I_SHDN] |=> state_reg == MBC_ST_OFF ##1 !main_switch_drive && !rectifier_drive;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("shutdown ignored");

	property p_burst_entry;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == MBC_ST_TRACK && burst_cause && !off_cause && !ovt_latch_reg
		|=> state_reg == MBC_ST_BURST && duty_reg == DUTY_BURST;
	endproperty
	a_burst_entry: assert property (p_burst_entry) else $error("burst entry wrong");

	property p_sleep_idle;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == MBC_ST_SLEEP |-> ##1 !main_switch_drive;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("main on in sleep");

	property p_period;
		@(posedge clk_sys) disable iff (!reset_n)
		pwm_reg == PWM_LAST |=> pwm_reg == 12'h000 ##1 pwm_reg == 12'h001;
	endproperty
	a_period: assert property (p_period) else $error("pwm period wrong");

endmodule

`default_nettype wire

// file: dv/mbc_stage_model.sv
// power stage and comparator model for the boost mode controller
`timescale 1ns/1ns
`default_nettype none
`include "mbc_params.svh"
module mbc_stage_model
#(
	parameter logic [15:0] SRC_ON_MV = 16'h010E
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// gate drives
	input wire logic main_switch_drive,
	input wire logic rectifier_drive,
	// analog levels in mV, mA and C
	input wire logic [15:0] vout_mv,
	input wire logic [15:0] source_mv,
	input wire logic [15:0] coil_ma,
	input wire logic [15:0] die_c,
	// comparators
	output logic vout_above_0v8,
	output logic vout_above_2v,
	output logic source_sense_below_off,
	output logic source_sense_above_on,
	output logic source_sense_below_450mv,
	output logic overcurrent_protection,
	output logic overtemperature_protection,
	output logic temp_below_130c,
	// sticky gate overlap or short gap
	output logic gate_fault
);
	logic main_q, rect_q;
	logic [7:0] gap;
	assign vout_above_0v8 = vout_mv >= 16'h0320;
	assign vout_above_2v = vout_mv > 16'h07D0;
	assign source_sense_below_off = source_mv < 16'h00F0;
	assign source_sense_above_on = source_mv >= SRC_ON_MV;
	assign source_sense_below_450mv = source_mv < 16'h01C2;
	assign overcurrent_protection = coil_ma >= 16'h0708;
	assign overtemperature_protection = die_c >= 16'h009B;
	assign temp_below_130c = die_c < 16'h0082;
	// gap since last drive fall, checked at main rise
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			main_q <= 1'b0;
			rect_q <= 1'b0;
			gap <= 8'hFF;
			gate_fault <= 1'b0;
		end
		else
		begin
			main_q <= main_switch_drive;
			rect_q <= rectifier_drive;
			if ((main_q && !main_switch_drive) || (rect_q && !rectifier_drive))
				gap <= 8'h00;
			else if (gap != 8'hFF)
				gap <= gap + 8'h01;
			if (main_switch_drive && !main_q && gap < 8'(`MBC_DEAD_CYCLES))
				gate_fault <= 1'b1;
			if (main_switch_drive && rectifier_drive)
				gate_fault <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: dv/mbc_top_bench.sv
// self-checking bench for the boost mode controller
`timescale 1ns/1ns
`default_nettype none
`include "mbc_params.svh"
module mbc_top_bench
	import mbc_pkg::*;
;
	logic clk_sys, reset_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d0, d1, d2, d3, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic vo08, vo2, sbo, sao, s450, ocp, otp, t130, gate_fault, power_rose, main_d, rect_d;
	logic [15:0] vout_mv, src_mv, coil_ma, die_c;
	logic [2:0] cause;
	logic [1:0] off;
	int error_cnt, samples_checked, hm, hr;
	mbc_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .shutdown_pin_n(!off[0]), .vout_above_0v8(vo08),
		.vout_above_2v(vo2), .source_sense_below_off(sbo), .source_sense_above_on(sao),
		.source_reversed(off[1]), .overcurrent_protection(ocp), .overtemperature_protection(otp),
		.temp_below_130c(t130), .voltage_feedback_at_target(cause[0]), .source_sense_below_450mv(s450),
		.output_current_limit(cause[2]), .input_power_rose(power_rose), .main_switch_drive(main_d),
		.rectifier_drive(rect_d));
	mbc_stage_model PWR (.clk_sys(clk_sys), .reset_n(reset_n), .main_switch_drive(main_d),
		.rectifier_drive(rect_d), .vout_mv(vout_mv), .source_mv(cause[1] ? 16'h0190 : src_mv),
		.coil_ma(coil_ma), .die_c(die_c), .vout_above_0v8(vo08), .vout_above_2v(vo2),
		.source_sense_below_off(sbo), .source_sense_above_on(sao), .source_sense_below_450mv(s450),
		.overcurrent_protection(ocp), .overtemperature_protection(otp), .temp_below_130c(t130),
		.gate_fault(gate_fault));
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic test_done;
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo;
		error_cnt++;
		$display("CHECK FAILED at %0t: wait timed out", $time);
		test_done();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw_ok, w_ok, b_ok;
		int n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; !b_ok; n++)
		begin
			@(posedge clk_sys);
			if (n > 100)
				tmo();
			if (!aw_ok && s_axi_awready === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (aw_ok && w_ok && s_axi_bvalid === 1'b1)
			begin
				b_ok = 1'b1;
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
		@(posedge clk_sys);
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar_ok, r_ok;
		int n;
		ar_ok = 1'b0;
		r_ok = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; !r_ok; n++)
		begin
			@(posedge clk_sys);
			if (n > 100)
				tmo();
			if (!ar_ok && s_axi_arready === 1'b1)
			begin
				ar_ok = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
			else if (ar_ok && s_axi_rvalid === 1'b1)
			begin
				r_ok = 1'b1;
				v = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
		@(posedge clk_sys);
	endtask
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] rs;
		axi_read(a, v, rs);
		chk(v, exp);
		chk(32'(rs), 32'h0);
	endtask
	task automatic wait_state(input mbc_state_e s);
		logic [31:0] v;
		logic [1:0] rs;
		int n;
		v = 32'h0000_0007;
		for (n = 0; n < 3000 && v[2:0] !== s; n++)
			axi_read(`MBC_OFS_STATUS, v, rs);
		if (v[2:0] !== s)
			tmo();
		chk(32'(v[2:0]), 32'(s));
	endtask
	task automatic wait_rise;
		logic prev;
		int n;
		prev = 1'b1;
		for (n = 0; !(main_d === 1'b1 && prev === 1'b0); n++)
		begin
			prev = main_d;
			@(posedge clk_sys);
			if (n > 3000)
				tmo();
		end
	endtask
	initial
	begin
		error_cnt = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		power_rose = 1'b1;
		vout_mv = 16'h0000;
		src_mv = 16'h0000;
		coil_ma = 16'h0000;
		die_c = 16'h0019;
		cause = 3'h0;
		off = 2'h0;
		cyc(2);
		reset_n <= 1'b1;
		cyc(1);
		reg_chk(`MBC_OFS_CTRL, `MBC_CTRL_RESET);
		reg_chk(`MBC_OFS_SDUTY, `MBC_SDUTY_RESET);
		axi_read(8'h10, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'h2);
		axi_write(8'h10, 32'hFFFFFFFF, r);
		chk(32'(r), 32'h2);
		axi_write(`MBC_OFS_SDUTY, 32'hFFFFF3E8, r);
		reg_chk(`MBC_OFS_SDUTY, 32'h000003E8);
		src_mv <= 16'h01F4;
		wait_state(MBC_ST_SOFT);
		cyc(50);
		chk({30'h0, main_d, rect_d}, 32'h0);
		vout_mv <= 16'h03E8;
		wait_state(MBC_ST_STARTUP);
		hm = 0;
		hr = 0;
		repeat (`MBC_PWM_CYCLES)
		begin
			@(posedge clk_sys);
			hm += (main_d === 1'b1);
			hr += (rect_d === 1'b1);
		end
		chk(32'(hm), 32'h000003E8);
		chk(32'(hr), 32'h0);
		wait_rise();
		cyc(5);
		coil_ma <= 16'h0708;
		#1 chk(32'(main_d), 32'h0);
		cyc(1);
		coil_ma <= 16'h0000;
		vout_mv <= 16'h09C4;
		wait_state(MBC_ST_TRACK);
		wait_rise();
		axi_read(`MBC_OFS_DUTY, d0, r);
		wait_rise();
		axi_read(`MBC_OFS_DUTY, d1, r);
		wait_rise();
		power_rose <= 1'b0;
		axi_read(`MBC_OFS_DUTY, d2, r);
		wait_rise();
		axi_read(`MBC_OFS_DUTY, d3, r);
		chk((d1 > d0) ? d1 - d0 : d0 - d1, 32'h00000019);
		chk(d2 - d1, d1 - d0);
		chk(d3 - d2, d1 - d2);
		wait_rise();
		cyc(5);
		coil_ma <= 16'h0708;
		#1 chk(32'(main_d), 32'h0);
		cyc(20);
		chk(32'(rect_d), 32'h1);
		coil_ma <= 16'h0000;
		wait_rise();
		chk(32'(rect_d), 32'h0);
		cyc(5);
		die_c <= 16'h00A0;
		#1 chk(32'(main_d), 32'h0);
		cyc(1);
		wait_state(MBC_ST_OVERTEMP);
		cyc(12);
		chk(32'(rect_d), 32'h1);
		die_c <= 16'h008C;
		vout_mv <= 16'h01F4;
		cyc(100);
		axi_read(`MBC_OFS_STATUS, d, r);
		chk(32'(d[2:0]), 32'(MBC_ST_OVERTEMP));
		die_c <= 16'h0019;
		wait_state(MBC_ST_SOFT);
		vout_mv <= 16'h09C4;
		wait_state(MBC_ST_TRACK);
		for (int i = 0; i < 3; i++)
		begin
			cause <= 3'h1 << i;
			wait_state(MBC_ST_BURST);
			reg_chk(`MBC_OFS_DUTY, `MBC_BURST_DUTY);
			if (i == 0)
			begin
				cyc(8000);
				axi_read(`MBC_OFS_STATUS, d, r);
				chk({27'h0, d[12:8]}, 32'h00000003);
			end
			cause <= 3'h0;
			wait_state(MBC_ST_TRACK);
		end
		for (int i = 0; i < 2; i++)
		begin
			off <= 2'h1 << i;
			wait_state(MBC_ST_OFF);
			chk({30'h0, main_d, rect_d}, 32'h0);
			off <= 2'h0;
			wait_state(MBC_ST_TRACK);
		end
		axi_write(`MBC_OFS_CTRL, 32'h00190000, r);
		chk(32'(r), 32'h0);
		wait_state(MBC_ST_OFF);
		axi_write(`MBC_OFS_CTRL, `MBC_CTRL_RESET, r);
		wait_state(MBC_ST_TRACK);
		src_mv <= 16'h00C8;
		wait_state(MBC_ST_OFF);
		src_mv <= 16'h00FF;
		cyc(200);
		axi_read(`MBC_OFS_STATUS, d, r);
		chk({28'h0, d[3:0]}, 32'h00000008);
		src_mv <= 16'h01F4;
		wait_state(MBC_ST_TRACK);
		chk(32'(gate_fault), 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
